/* File: core/twc_compare_unit.sv */
// twc_compare_unit: integer, zone and float compare with three result bits
// assumes: the sequencer holds operands, op and flags stable with I_EN,
// and writes O_WR_BITS into its bit store at O_WR_DEST on O_WR.
`timescale 1ns/10ps
module twc_compare_unit
    import twc_pkg::*;
#(
    parameter int DEST_W    = DEST_W_DEF,
    parameter int DEST_LAST = DEST_LAST_DEF
)
(
    input  wire logic              I_CLK,
    input  wire logic              I_RST_B,
    input  wire logic              I_EN,
    input  wire logic [1:0]        I_OP,
    input  wire logic              I_WIDE,
    input  wire logic              I_PULSE,
    input  wire logic              I_COUNTER_OPERAND,
    input  wire logic [31:0]       I_OPA,
    input  wire logic [31:0]       I_OPB,
    input  wire logic [31:0]       I_TEST,
    input  wire logic [DEST_W-1:0] I_DEST,
    input  wire logic              I_ERR_CLR,
    output logic                   O_WR,
    output logic [DEST_W-1:0]      O_WR_DEST,
    output logic [2:0]             O_WR_BITS,
    output logic                   O_DONE,
    output logic                   O_ERR_FLAG,
    output logic [15:0]            O_ERR_CODE
);

    // refuse widths and limits the range check cannot serve
    generate
        if (DEST_W < 2 || DEST_W > 31)
        begin : g_bad_width
            $error("twc_compare_unit: DEST_W must be 2..31");
        end
        if (DEST_LAST < RES_SPAN - 1 || DEST_LAST >= (1 << DEST_W))
        begin : g_bad_last
            $error("twc_compare_unit: DEST_LAST out of range");
        end
    endgenerate

    // complete state of the unit
    typedef struct packed
    {
        logic              en_prev;
        logic              wr;
        logic [DEST_W-1:0] wr_dest;
        logic [2:0]        bits;
        logic              done;
        logic              err_flag;
        logic [15:0]       err_code;
    } twc_state_t;

    localparam logic [DEST_W:0] DEST_LAST_X = (DEST_W+1)'(DEST_LAST);
    localparam logic [DEST_W:0] SPAN_TOP    = (DEST_W+1)'(RES_SPAN - 1);
    // operand words that pass the width stage: one, two and the test value
    localparam int              N_OPND      = 3;

    twc_state_t st_ff;
    twc_state_t nxt_st;

    logic signed [31:0] int_a;
    logic signed [31:0] int_b;
    logic signed [31:0] int_t;
    logic signed [31:0] zone_lo;
    logic signed [31:0] zone_hi;
    logic               fp_gt;
    logic               fp_eq;
    logic               fp_lt;
    logic               fp_bad;
    logic               fire;
    logic               range_bad;
    logic               counter_bad;
    logic [DEST_W:0]    dest_top;
    logic [2:0]         int_bits;
    logic [2:0]         zone_bits;
    logic [2:0]         fp_bits;
    logic               op_ok;
    logic               refuse;
    logic        [31:0] op_raw [N_OPND];
    logic signed [31:0] op_ext [N_OPND];

    // float ordering, always on full 32-bit words
    twc_float_order u_float_order
    (
        .i_opa (I_OPA),
        .i_opb (I_OPB),
        .o_gt  (fp_gt),
        .o_eq  (fp_eq),
        .o_lt  (fp_lt),
        .o_bad (fp_bad)
    );

    // operand words in a fixed order for the width stage
    assign op_raw[0] = I_OPA;
    assign op_raw[1] = I_OPB;
    assign op_raw[2] = I_TEST;

    // operand width: narrow form sign-extends the low half of each word
    generate
        for (genvar g = 0; g < N_OPND; g++)
        begin : g_width
            assign op_ext[g] = I_WIDE
                             ? op_raw[g]
                             : {{(WIDE_W-NARROW_W){op_raw[g][NARROW_W-1]}},
                                op_raw[g][NARROW_W-1:0]};
        end
    endgenerate

    // named views of the extended operands
    assign int_a = op_ext[0];
    assign int_b = op_ext[1];
    assign int_t = op_ext[2];

    // signed two-operand compare
    always_comb
    begin
        int_bits = 3'h0;
        if (int_a > int_b)
            int_bits[RES_FIRST] = 1'b1;
        else if (int_a < int_b)
            int_bits[RES_THIRD] = 1'b1;
        else
            int_bits[RES_MIDDLE] = 1'b1;
    end

    // zone bounds, swapped when handed over reversed
    always_comb
    begin
        if (int_a > int_b)
        begin
            zone_lo = int_b;
            zone_hi = int_a;
        end
        else
        begin
            zone_lo = int_a;
            zone_hi = int_b;
        end
    end

    // zone classification of the test value
    always_comb
    begin
        zone_bits = 3'h0;
        if (int_t < zone_lo)
            zone_bits[RES_FIRST] = 1'b1;
        else if (int_t > zone_hi)
            zone_bits[RES_THIRD] = 1'b1;
        else
            zone_bits[RES_MIDDLE] = 1'b1;
    end

    // float outcome in the same bit order as the integer compare
    always_comb
    begin
        fp_bits = 3'h0;
        fp_bits[RES_FIRST]  = fp_gt;
        fp_bits[RES_MIDDLE] = fp_eq;
        fp_bits[RES_THIRD]  = fp_lt;
    end

    // request qualification: level form or rising edge in pulse form;
    // edge memory samples the enable every cycle, whatever the op code
    assign fire = op_ok
                & (I_PULSE ? (I_EN & ~st_ff.en_prev) : I_EN);

    // highest bit the write would touch, one bit wider to avoid wrap
    assign dest_top  = {1'b0, I_DEST} + SPAN_TOP;
    assign range_bad = (dest_top > DEST_LAST_X);

    // a counter operand needs the wide form; float has no counter case
    assign counter_bad = I_COUNTER_OPERAND & ~I_WIDE
                       & (I_OP != OP_FLOAT);

    // only the three defined codes are taken; code 3 never sets an error
    always_comb
    begin
        case (I_OP)
            OP_INT,
            OP_ZONE,
            OP_FLOAT:
            begin
                op_ok = 1'b1;
            end
            default:
            begin
                op_ok = 1'b0;
            end
        endcase
    end

    // any refusal of a request; the same term guards the error clear
    assign refuse = range_bad | counter_bad
                  | ((I_OP == OP_FLOAT) & fp_bad);

    // next state: evaluate, refuse, or hold
    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.en_prev = I_EN;
        nxt_st.wr      = 1'b0;
        nxt_st.done    = 1'b0;
        // enable low: nothing evaluated, result bits keep their value
        if (fire)
        begin
            nxt_st.done = 1'b1;
            if (range_bad)
            begin
                nxt_st.err_flag = 1'b1;
                nxt_st.err_code = ERR_RANGE;
            end
            else if (counter_bad)
            begin
                nxt_st.err_flag = 1'b1;
                nxt_st.err_code = ERR_COUNTER;
            end
            else
            begin
                case (I_OP)
                    OP_INT:
                    begin
                        nxt_st.wr      = 1'b1;
                        nxt_st.wr_dest = I_DEST;
                        nxt_st.bits    = int_bits;
                    end
                    OP_ZONE:
                    begin
                        nxt_st.wr      = 1'b1;
                        nxt_st.wr_dest = I_DEST;
                        nxt_st.bits    = zone_bits;
                    end
                    OP_FLOAT:
                    begin
                        if (fp_bad)
                        begin
                            nxt_st.err_flag = 1'b1;
                            nxt_st.err_code = ERR_FLOAT;
                        end
                        else
                        begin
                            nxt_st.wr      = 1'b1;
                            nxt_st.wr_dest = I_DEST;
                            nxt_st.bits    = fp_bits;
                        end
                    end
                    default:
                    begin
                        nxt_st.done = 1'b0;     // unknown op ignored
                    end
                endcase
            end
        end
        // clear from the sequencer loses against a new error
        if (I_ERR_CLR && !(fire && refuse))
        begin
            nxt_st.err_flag = 1'b0;
        end
    end

    // state register
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            st_ff.en_prev  <= 1'b0;
            st_ff.wr       <= 1'b0;
            st_ff.wr_dest  <= '0;
            st_ff.bits     <= RES_RST;
            st_ff.done     <= 1'b0;
            st_ff.err_flag <= 1'b0;
            st_ff.err_code <= CODE_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign O_WR       = st_ff.wr;
    assign O_WR_DEST  = st_ff.wr_dest;
    assign O_WR_BITS  = st_ff.bits;
    assign O_DONE     = st_ff.done;
    assign O_ERR_FLAG = st_ff.err_flag;
    assign O_ERR_CODE = st_ff.err_code;

endmodule

/* File: core/twc_pkg.sv */
// twc_pkg: constants and types shared by the three way compare unit
// assumes: included before every core file that imports it
package twc_pkg;

    // operation select, one code per compare family
    typedef enum logic [1:0]
    {
        OP_INT   = 2'h0,
        OP_ZONE  = 2'h1,
        OP_FLOAT = 2'h2
    } twc_op_t;

    // positions of the three result bits relative to the destination
    localparam int RES_FIRST  = 0;
    localparam int RES_MIDDLE = 1;
    localparam int RES_THIRD  = 2;
    localparam int RES_SPAN   = 3;

    // operand widths of the integer and zone compares
    localparam int NARROW_W = 16;
    localparam int WIDE_W   = 32;

    // single precision layout
    localparam int FP_SIGN    = 31;
    localparam int FP_EXP_MSB = 30;
    localparam int FP_EXP_LSB = 23;
    localparam logic [7:0] FP_EXP_ALL = 8'hff;

    // error codes loaded into the error code word
    localparam logic [15:0] ERR_RANGE   = 16'h2003;
    localparam logic [15:0] ERR_FLOAT   = 16'h2013;
    localparam logic [15:0] ERR_COUNTER = 16'h2001;

    // reset values
    localparam logic [2:0]  RES_RST  = 3'h0;
    localparam logic [15:0] CODE_RST = 16'h0000;

    // default destination width and last valid destination bit index
    localparam int DEST_W_DEF    = 16;
    localparam int DEST_LAST_DEF = 16'hffff;

endpackage

/* File: core/twc_float_order.sv */
// twc_float_order: orders two single precision values, pure logic
// assumes: operands are stable for the cycle in which they are sampled
`timescale 1ns/10ps
module twc_float_order
    import twc_pkg::*;
(
    input  wire logic [31:0] i_opa,
    input  wire logic [31:0] i_opb,
    output logic             o_gt,
    output logic             o_eq,
    output logic             o_lt,
    output logic             o_bad
);

    logic [31:0] key_a;
    logic [31:0] key_b;
    logic        zero_a;
    logic        zero_b;

    // both zeros fold onto one key so that +0 equals -0
    assign zero_a = (i_opa[FP_SIGN-1:0] == 31'h0);
    assign zero_b = (i_opb[FP_SIGN-1:0] == 31'h0);

    // map to an unsigned sortable key: negatives inverted, positives offset
    always_comb
    begin
        if (zero_a)
            key_a = 32'h80000000;
        else if (i_opa[FP_SIGN])
            key_a = ~i_opa;
        else
            key_a = i_opa ^ 32'h80000000;
        if (zero_b)
            key_b = 32'h80000000;
        else if (i_opb[FP_SIGN])
            key_b = ~i_opb;
        else
            key_b = i_opb ^ 32'h80000000;
    end

    // outcome, always exactly one of three; bad when either exponent is all ones (not a number or infinity)
    assign o_gt  = (key_a > key_b);
    assign o_eq  = (key_a == key_b);
    assign o_lt  = (key_a < key_b);
    assign o_bad = (i_opa[FP_EXP_MSB:FP_EXP_LSB] == FP_EXP_ALL)
                 | (i_opb[FP_EXP_MSB:FP_EXP_LSB] == FP_EXP_ALL);

endmodule

/* File: sim/twc_props.sv */
// twc_props: port checker for the three way compare unit
// assumes: bound to twc_compare_unit, one clock, reset active low
`timescale 1ns/10ps
module twc_props
    import twc_pkg::*;
#(
    parameter int DEST_W    = 16,
    parameter int DEST_LAST = 16'hffff
)
(
    input wire logic              I_CLK,
    input wire logic              I_RST_B,
    input wire logic              I_EN,
    input wire logic [1:0]        I_OP,
    input wire logic              I_WIDE,
    input wire logic              I_PULSE,
    input wire logic              I_COUNTER_OPERAND,
    input wire logic [31:0]       I_OPA,
    input wire logic [31:0]       I_OPB,
    input wire logic [31:0]       I_TEST,
    input wire logic [DEST_W-1:0] I_DEST,
    input wire logic              I_ERR_CLR,
    input wire logic              O_WR,
    input wire logic [DEST_W-1:0] O_WR_DEST,
    input wire logic [2:0]        O_WR_BITS,
    input wire logic              O_DONE,
    input wire logic              O_ERR_FLAG,
    input wire logic [15:0]       O_ERR_CODE
);
    logic signed [31:0] a, b, t, lo, hi;
    logic               lvl, rok, acc;
    logic [2:0]         ei, ez;
    // expected bits of a level-form request taken this cycle
    always_comb
    begin
        a = I_WIDE ? I_OPA : {{16{I_OPA[15]}}, I_OPA[15:0]};
        b = I_WIDE ? I_OPB : {{16{I_OPB[15]}}, I_OPB[15:0]};
        t = I_WIDE ? I_TEST : {{16{I_TEST[15]}}, I_TEST[15:0]};
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        ei = {a < b, a == b, a > b};
        ez = {t > hi, t >= lo && t <= hi, t < lo};
        lvl = I_EN && !I_PULSE;
        rok = int'(I_DEST) + 2 <= DEST_LAST;
        acc = lvl && rok && (I_WIDE || !I_COUNTER_OPERAND);
    end
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);
    a_int_order: assert property (
        acc && I_OP == 2'h0 |=> O_WR && O_WR_BITS == $past(ei))
        else $error("integer result wrong");
    a_zone_order: assert property (
        acc && I_OP == 2'h1 |=> O_WR && O_WR_BITS == $past(ez))
        else $error("zone result wrong");
    a_one_hot: assert property (
        O_WR |-> $onehot(O_WR_BITS))
        else $error("result not one hot");
    a_bits_hold: assert property (
        !O_WR |-> $stable(O_WR_BITS) && $stable(O_WR_DEST))
        else $error("result moved without write");
    a_no_spur: assert property (
        !$past(I_EN) |-> !O_DONE)
        else $error("done without enable");
    a_pulse_once: assert property (
        I_PULSE && $past(I_EN) && $past(I_RST_B) |=> !O_DONE)
        else $error("pulse form evaluated twice");
    a_range_err: assert property (
        lvl && !rok && I_OP != 2'h3 |=> O_DONE && !O_WR && O_ERR_FLAG
        && O_ERR_CODE == ERR_RANGE)
        else $error("range refusal wrong");
    a_ctr_err: assert property (
        lvl && rok && !I_OP[1] && I_COUNTER_OPERAND && !I_WIDE |=> O_DONE
        && !O_WR && O_ERR_FLAG && O_ERR_CODE == ERR_COUNTER)
        else $error("counter refusal wrong");
    a_flag_sticky: assert property (
        $fell(O_ERR_FLAG) |-> $past(I_ERR_CLR))
        else $error("error flag dropped alone");
    c_int: cover property (acc && I_OP == 2'h0 ##1 O_WR);
    c_zone: cover property (acc && I_OP == 2'h1 ##1 O_WR);
    c_range: cover property (lvl && !rok ##1 O_ERR_FLAG);
    c_set_wins: cover property (I_ERR_CLR && lvl && !rok ##1 O_ERR_FLAG);
endmodule

bind twc_compare_unit twc_props #(.DEST_W(DEST_W), .DEST_LAST(DEST_LAST))
    u_props (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_EN(I_EN), .I_OP(I_OP),
    .I_WIDE(I_WIDE), .I_PULSE(I_PULSE), .I_OPA(I_OPA), .I_OPB(I_OPB),
    .I_COUNTER_OPERAND(I_COUNTER_OPERAND), .I_TEST(I_TEST),
    .I_DEST(I_DEST), .I_ERR_CLR(I_ERR_CLR), .O_WR(O_WR),
    .O_WR_DEST(O_WR_DEST), .O_WR_BITS(O_WR_BITS), .O_DONE(O_DONE),
    .O_ERR_FLAG(O_ERR_FLAG), .O_ERR_CODE(O_ERR_CODE));

/* File: sim/twc_bit_store.sv */
// twc_bit_store: sequencer side bit store taking result writes
// assumes: write strobe and bits registered by the compare unit
`timescale 1ns/10ps
module twc_bit_store
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_dest,
    input  wire logic [2:0]  i_bits,
    output logic [2:0]       o_bits,
    output logic [15:0]      o_dest
);
    // keeps the three bits of the last write
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_bits <= 3'h0;
            o_dest <= 16'h0;
        end
        else if (i_wr)
        begin
            o_bits <= i_bits;
            o_dest <= i_dest;
        end
    end
endmodule

/* File: sim/tb_three_way_compare_unit.sv */
// tb_three_way_compare_unit: random and corner compares with self check
// assumes: twc_props bound to the unit, bit store as the far side
`timescale 1ns/10ps
module tb_three_way_compare_unit
    import twc_pkg::*;
();
    logic        clk, rst_b, en, wide, pulse, ctr, clr, wr, done, flag;
    logic [1:0]  op;
    logic [31:0] opa, opb, tst, r, a, b, t;
    logic [15:0] dest, wdest, code, odest, pdest, xc;
    logic [2:0]  bits, sbits, prev, xb;
    logic        bad;
    logic [31:0] fa [4];
    logic [31:0] fb [4];
    logic [2:0]  fe [4];
    int          err_count, n_checks, seed, dcnt, i, k;
    twc_compare_unit #(.DEST_LAST(16'h00ff)) dut_u (.I_CLK(clk),
        .I_RST_B(rst_b), .I_EN(en), .I_OP(op), .I_WIDE(wide),
        .I_PULSE(pulse), .I_COUNTER_OPERAND(ctr), .I_OPA(opa), .I_OPB(opb),
        .I_TEST(tst), .I_DEST(dest), .I_ERR_CLR(clr), .O_WR(wr),
        .O_WR_DEST(odest), .O_WR_BITS(bits), .O_DONE(done), .O_ERR_FLAG(flag),
        .O_ERR_CODE(code));
    twc_bit_store store_u (.i_clk(clk), .i_rst_b(rst_b), .i_wr(wr),
        .i_dest(odest), .i_bits(bits), .o_bits(sbits), .o_dest(wdest));
    // clock, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // counts done pulses away from the edge
    always @(negedge clk)
    begin
        if (done)
            dcnt++;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [31:0] sx(input logic [31:0] v, input logic w);
        return w ? v : {{16{v[15]}}, v[15:0]};
    endfunction
    function automatic logic [2:0] e_int(input logic signed [31:0] x, y);
        return {x < y, x == y, x > y};
    endfunction
    function automatic logic [2:0] e_zone(input logic signed [31:0] x, y, z);
        logic signed [31:0] lo, hi;
        lo = x < y ? x : y;
        hi = x < y ? y : x;
        return {z > hi, z >= lo && z <= hi, z < lo};
    endfunction
    // one request held for n cycles, then a quiet gap
    task automatic run(input logic [1:0] o, input logic [31:0] x, y, z,
                       input logic w, p, c, input logic [15:0] d, int n);
        int d0;
        int xn;
        @(posedge clk);
        d0 = dcnt;
        xn = (o == 2'h3) ? 0 : (p ? 1 : n);
        op <= o;
        opa <= x;
        opb <= y;
        tst <= z;
        wide <= w;
        pulse <= p;
        ctr <= c;
        dest <= d;
        en <= 1'b1;
        repeat (n) @(posedge clk);
        en <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("done count", dcnt - d0, xn);
    endtask
    // watchdog against a hung run
    initial
    begin
        #600000;
        err_count++;
        test_done;
    end
    initial
    begin
        {rst_b, en, wide, pulse, ctr, clr, op, dest} = '0;
        {opa, opb, tst} = '0;
        seed = 32'h1852248b;
        fa = '{32'h3f800000, 32'hbf800000, 32'h00000000, 32'h7f800000};
        fb = '{32'h40000000, 32'hc0000000, 32'h80000000, 32'h3f800000};
        fe = '{3'h4, 3'h1, 3'h2, 3'h0};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // random compares, bounds in either order, both widths and forms
        for (i = 0; i < 300; i++)
        begin
            r = $random(seed);
            a = $random(seed);
            b = r[5] ? a : $random(seed);
            t = r[6] ? b : $random(seed);
            prev = sbits;
            pdest = wdest;
            run({1'b0, r[4]}, a, b, t, r[0], r[1], r[7], {8'h00, r[15:8]},
                1 + r[3:2]);
            a = sx(a, r[0]);
            b = sx(b, r[0]);
            t = sx(t, r[0]);
            // refused when dest+2 passes the last bit or a counter is narrow
            bad = (r[15:9] == 7'h7f) || (r[7] && !r[0]);
            xc = (r[15:9] == 7'h7f) ? ERR_RANGE : ERR_COUNTER;
            xb = bad ? prev : r[4] ? e_zone(a, b, t) : e_int(a, b);
            if (r[4])
                chk("zone bits", sbits, xb);
            else
                chk("int bits", sbits, xb);
            chk("dest", wdest, bad ? pdest : {8'h00, r[15:8]});
            if (bad)
                chk("refuse code", code, xc);
        end
        // float order, signed zeros and an infinity refused
        for (k = 0; k < 4; k++)
        begin
            run(2'h2, fa[k], fb[k], 32'h0, k[0], 1'b0, 1'b0, 16'h0010, 1);
            if (k < 3)
                chk("float", bits, fe[k]);
            else
                chk("float err", code, ERR_FLOAT);
        end
        // last legal destination, then one past it
        run(2'h0, 32'h5, 32'h3, 32'h0, 1'b1, 1'b0, 1'b0, 16'h00fd, 1);
        chk("edge dest", wdest, 16'h00fd);
        prev = bits;
        run(2'h1, 32'h1, 32'h9, 32'h0, 1'b1, 1'b0, 1'b0, 16'h00fe, 1);
        chk("range code", code, ERR_RANGE);
        chk("range flag", flag, 1'b1);
        chk("bits held", bits, prev);
        run(2'h0, 32'h1, 32'h2, 32'h0, 1'b0, 1'b0, 1'b1, 16'h0020, 1);
        chk("ctr code", code, ERR_COUNTER);
        // code 3 is ignored even with a destination out of range
        run(2'h3, 32'h1, 32'h2, 32'h0, 1'b1, 1'b0, 1'b0, 16'h00fe, 1);
        chk("ignored op code", code, ERR_COUNTER);
        // error flag cleared by the sequencer
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(negedge clk);
        chk("flag clear", flag, 1'b0);
        // clear and a new refusal on one edge: the set wins
        @(posedge clk);
        dest <= 16'h00fe;
        op <= 2'h0;
        pulse <= 1'b0;
        en <= 1'b1;
        clr <= 1'b1;
        @(posedge clk);
        en <= 1'b0;
        clr <= 1'b0;
        @(negedge clk);
        chk("set wins", flag, 1'b1);
        test_done;
    end
endmodule
